// >>> rtl/cancer_defs.svh
// offsets, field positions, reset values and timing counts of the control and event block
`ifndef CANCER_DEFS_SVH
`define CANCER_DEFS_SVH
`define CANCER_ADDR_MODE      8'h00
`define CANCER_ADDR_CTRL      8'h01
`define CANCER_ADDR_BT_ONE    8'h04
`define CANCER_ADDR_BT_TWO    8'h05
`define CANCER_ADDR_BAUD      8'h06
`define CANCER_ADDR_OUTCFG    8'h07
`define CANCER_ADDR_IRQ_MASK  8'h08
`define CANCER_ADDR_FLAGS     8'h09
`define CANCER_RESET_BYTE     8'h00
`define CANCER_MODE_INIT      0
`define CANCER_MODE_SOFTCLR   1
`define CANCER_MODE_BUSOFF    2
`define CANCER_CTRL_CATCH     0
`define CANCER_CTRL_TXCHK     1
`define CANCER_CTRL_SLEEP     2
`define CANCER_CTRL_STOVF     3
`define CANCER_CTRL_TEST      6
`define CANCER_CTRL_WMASK     8'h77
`define CANCER_WARN_LEVEL     8'd96
`define CANCER_PASSIVE_LEVEL  8'd128
`define CANCER_TXCHK_LIMIT    3'd4
`define CANCER_IDLE_BITS      4'd11
`define CANCER_IDLE_PHASES    8'd128
`define CANCER_STAMP_BASE     9'd32
`endif

// >>> rtl/cancer_pkg.sv
// types shared by the control and event block
package cancer_pkg;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cancer_host_t;

  typedef struct packed {
    logic       rx_stored;
    logic       tx_done;
    logic       remote_rx;
    logic       txchk_err;
    logic       bit_tick;
    logic       recessive_bit;
  } cancer_proto_t;

  typedef enum logic [1:0] {
    CANCER_ACTIVE  = 2'b00,
    CANCER_BUSOFF  = 2'b01,
    CANCER_RECOVER = 2'b10
  } cancer_bus_t;
endpackage

// >>> rtl/cancer_event_regs.sv
// control, event flag and reset-behaviour register bank of the can controller
`timescale 1ns/100ps
//
// Summary of operation
// - hardware reset pin leaves bus-off at once, with no idle wait.
// - after soft clear, bus-off ends after 128 idle phases of 11 recessive bits.
// - timing, prescaler and output config clear on reset or soft clear plus init.
// - catch-all bit makes slot 0 take every otherwise unaccepted identifier.
// - transmit check enabled: error aborts frame and counts one up.
// - transmit check count of 4 enters bus-off and raises its flag.
// - sleep bit stops oscillator and bus activity until wake-up; warning and error-passive flags still set.
// - stamp overflow bit sets after any timer overflow, else reads 0.
// - stamp prescaler divides bit rate by 32, 64, 128 or 256.
// - stamp test bypasses prescaler; only in init mode, but the logic does not gate it on init mode; bit 7 stays 0.
// - writing 0 clears a flag, writing 1 leaves it; software clears all.
// - receive flag sets on stored message, holds while any ready bit set.
// - transmit flag sets when a transmit request finishes.
// - warning flag sets when an error counter reaches 96.
// - remote flag sets after a remote frame is received.
// - wake flag sets on wake-up; bus-off flag sets on bus-off entry.
// - error-passive flag sets when an error counter reaches 128.
// - transmit-check flag sets when the check counter reaches its limit.
// - flags set regardless of mask; interrupt pin only for masked-in flags.
// - first timing register readable, resets 00, writable only in init plus clear.
// - soft clear stops bus activity and returns control, flags, check count and stamp to reset values.
`include "cancer_defs.svh"

module cancer_event_regs (
  input  wire logic                    i_clk_sys,       // system clock
  input  wire logic                    i_reset_n,       // hardware reset pin, low active
  input  wire cancer_pkg::cancer_host_t i_host,         // host register access
  input  wire cancer_pkg::cancer_proto_t i_proto,       // protocol engine events
  input  wire logic [7:0]              i_rx_err_count,  // receive error counter
  input  wire logic [7:0]              i_tx_err_count,  // transmit error counter
  input  wire logic [15:0]             i_rx_ready,      // both receive-ready registers
  input  wire logic                    i_chip_select_n, // chip select, low active
  input  wire logic                    i_bus_in_a,      // receive input a
  input  wire logic                    i_bus_in_b,      // receive input b
  output logic [7:0]                   o_rdata,         // register read data
  output logic                         o_irq_n,         // interrupt pin, low active
  output logic                         o_bus_off,       // bus-off state
  output logic                         o_bus_stop,      // bus activity halted
  output logic                         o_osc_stop,      // oscillator stopped for sleep
  output logic                         o_catch_all_mode, // slot 0 catch-all
  output logic                         o_tx_abort,      // abort by error frame
  output logic                         o_stamp_tick,    // time-stamp timer clock
  output logic [7:0]                   o_bit_timing_one, // first timing register
  output logic [7:0]                   o_bit_timing_two, // second timing register
  output logic [7:0]                   o_baud_prescaler, // baud prescaler
  output logic [7:0]                   o_output_config  // output configuration
);
  import cancer_pkg::*;

  // ==========================================================
  // register access decode
  logic [7:0]  mode_ff, ctrl_ff, mask_ff, flags_ff;
  logic [7:0]  bt_one_ff, bt_two_ff, baud_ff, outcfg_ff;
  logic [2:0]  txchk_cnt_ff;
  logic [15:0] stamp_ff;
  logic [8:0]  pre_cnt_ff;
  logic [3:0]  idle_bits_ff;
  logic [7:0]  idle_phases_ff;
  logic        a_prev_ff, b_prev_ff;
  cancer_bus_t bus_ff;

  wire wr_mode   = i_host.wr && i_host.addr == `CANCER_ADDR_MODE;
  wire wr_ctrl   = i_host.wr && i_host.addr == `CANCER_ADDR_CTRL;
  wire wr_mask   = i_host.wr && i_host.addr == `CANCER_ADDR_IRQ_MASK;
  wire wr_flags  = i_host.wr && i_host.addr == `CANCER_ADDR_FLAGS;
  wire init_mode = mode_ff[`CANCER_MODE_INIT];
  wire soft_clear_request = mode_ff[`CANCER_MODE_SOFTCLR];
  wire protected_open = init_mode && soft_clear_request;
  wire sleep_enable   = ctrl_ff[`CANCER_CTRL_SLEEP];
  wire tx_check_enable = ctrl_ff[`CANCER_CTRL_TXCHK];
  wire stamp_test     = ctrl_ff[`CANCER_CTRL_TEST];

  // ==========================================================
  // wake-up and sleep
  wire fall_a  = a_prev_ff && !i_bus_in_a;
  wire fall_b  = b_prev_ff && !i_bus_in_b;
  wire wake_ev = sleep_enable && (!i_chip_select_n || fall_a || fall_b);
  wire active  = !sleep_enable && !soft_clear_request;

  // ==========================================================
  // transmit check and bus-off
  wire txchk_ev    = active && tx_check_enable && i_proto.txchk_err;
  wire txchk_limit = txchk_ev && txchk_cnt_ff == `CANCER_TXCHK_LIMIT - 3'd1;
  wire idle_bit    = i_proto.bit_tick && i_proto.recessive_bit;
  wire phase_done  = idle_bit && idle_bits_ff == `CANCER_IDLE_BITS - 4'd1;
  wire recover_end = phase_done && idle_phases_ff == `CANCER_IDLE_PHASES - 8'd1;
  wire bus_off_entry = txchk_limit && bus_ff != CANCER_BUSOFF;

  // ==========================================================
  // time-stamp prescaler
  function automatic logic [8:0] stamp_div(input logic [1:0] code);
    stamp_div = 9'(`CANCER_STAMP_BASE << code);
  endfunction
  wire pre_wrap  = pre_cnt_ff == stamp_div(ctrl_ff[5:4]) - 9'd1;
  wire stamp_adv = active && i_proto.bit_tick && (stamp_test || pre_wrap);
  wire stamp_ovf = stamp_adv && &stamp_ff;

  // ==========================================================
  // event flags: set wins over write-zero clear
  wire [7:0] flag_set = {
    txchk_limit,
    i_rx_err_count >= `CANCER_PASSIVE_LEVEL ||
      i_tx_err_count >= `CANCER_PASSIVE_LEVEL,
    bus_off_entry,
    wake_ev,
    active && i_proto.remote_rx,
    i_rx_err_count >= `CANCER_WARN_LEVEL ||
      i_tx_err_count >= `CANCER_WARN_LEVEL,
    active && i_proto.tx_done,
    (active && i_proto.rx_stored) || (flags_ff[0] && |i_rx_ready)
  };
  wire [7:0] flag_keep = wr_flags ? i_host.wdata : 8'hFF;
  wire [7:0] nxt_flags = (flags_ff & flag_keep) | flag_set;

  wire [7:0] nxt_ctrl = {1'b0, i_host.wdata[6:4],
                         ctrl_ff[`CANCER_CTRL_STOVF] | stamp_ovf, i_host.wdata[2:0]};

  logic [7:0] rd_mux;
  always_comb begin
    unique case (i_host.addr)
      `CANCER_ADDR_MODE:     rd_mux = {5'h00, bus_ff != CANCER_ACTIVE, mode_ff[1:0]};
      `CANCER_ADDR_CTRL:     rd_mux = ctrl_ff;
      `CANCER_ADDR_BT_ONE:   rd_mux = bt_one_ff;
      `CANCER_ADDR_BT_TWO:   rd_mux = bt_two_ff;
      `CANCER_ADDR_OUTCFG:   rd_mux = outcfg_ff;
      `CANCER_ADDR_IRQ_MASK: rd_mux = mask_ff;
      `CANCER_ADDR_FLAGS:    rd_mux = flags_ff;
      default:               rd_mux = 8'h00;
    endcase
  end

  // ==========================================================
  // registers
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      mode_ff <= `CANCER_RESET_BYTE;
      mask_ff <= `CANCER_RESET_BYTE;
      o_rdata <= `CANCER_RESET_BYTE;
      a_prev_ff <= 1'b1;
      b_prev_ff <= 1'b1;
    end else begin
      if (wr_mode) mode_ff <= {6'h00, i_host.wdata[1:0]};
      if (wr_mask) mask_ff <= i_host.wdata;
      o_rdata <= i_host.rd ? rd_mux : o_rdata;
      a_prev_ff <= i_bus_in_a;
      b_prev_ff <= i_bus_in_b;
    end
  end

  // soft clear returns these to reset values
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n || soft_clear_request) begin
      ctrl_ff      <= `CANCER_RESET_BYTE;
      flags_ff     <= `CANCER_RESET_BYTE;
      txchk_cnt_ff <= 3'd0;
      stamp_ff     <= 16'h0000;
      pre_cnt_ff   <= 9'h000;
    end else begin
      if (wr_ctrl) ctrl_ff <= nxt_ctrl & `CANCER_CTRL_WMASK | {4'h0, nxt_ctrl[3], 3'h0};
      else if (wake_ev) ctrl_ff[`CANCER_CTRL_SLEEP] <= 1'b0;
      else if (stamp_ovf) ctrl_ff[`CANCER_CTRL_STOVF] <= 1'b1;
      flags_ff <= nxt_flags;
      if (txchk_limit) txchk_cnt_ff <= 3'd0;
      else if (txchk_ev) txchk_cnt_ff <= txchk_cnt_ff + 3'd1;
      if (active && i_proto.bit_tick) pre_cnt_ff <= pre_wrap ? 9'h000 : pre_cnt_ff + 9'd1;
      if (stamp_adv) stamp_ff <= stamp_ff + 16'd1;
    end
  end

  // protected timing registers
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n || (protected_open && !i_host.wr)) begin
      bt_one_ff <= `CANCER_RESET_BYTE;
      bt_two_ff <= `CANCER_RESET_BYTE;
      baud_ff   <= `CANCER_RESET_BYTE;
      outcfg_ff <= `CANCER_RESET_BYTE;
    end else if (protected_open) begin
      if (i_host.addr == `CANCER_ADDR_BT_ONE) bt_one_ff <= i_host.wdata;
      if (i_host.addr == `CANCER_ADDR_BT_TWO) bt_two_ff <= i_host.wdata;
      if (i_host.addr == `CANCER_ADDR_BAUD)   baud_ff   <= i_host.wdata;
      if (i_host.addr == `CANCER_ADDR_OUTCFG) outcfg_ff <= i_host.wdata;
    end
  end

  // bus-off state and idle-phase recovery
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      bus_ff         <= CANCER_ACTIVE;
      idle_bits_ff   <= 4'd0;
      idle_phases_ff <= 8'd0;
    end else begin
      unique case (bus_ff)
        CANCER_ACTIVE:  if (txchk_limit) bus_ff <= CANCER_BUSOFF;
        CANCER_BUSOFF:  if (soft_clear_request) bus_ff <= CANCER_RECOVER;
        CANCER_RECOVER: if (recover_end) bus_ff <= CANCER_ACTIVE;
        default:        bus_ff <= CANCER_BUSOFF;
      endcase
      if (bus_ff != CANCER_RECOVER || (i_proto.bit_tick && !i_proto.recessive_bit)) begin
        idle_bits_ff <= 4'd0;
      end else if (idle_bit) begin
        idle_bits_ff <= phase_done ? 4'd0 : idle_bits_ff + 4'd1;
      end
      if (bus_ff != CANCER_RECOVER) idle_phases_ff <= 8'd0;
      else if (phase_done) idle_phases_ff <= idle_phases_ff + 8'd1;
    end
  end

  // outputs straight from flip-flops
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      o_irq_n <= 1'b1;
      o_bus_off <= 1'b0;
      o_bus_stop <= 1'b0;
      o_osc_stop <= 1'b0;
      o_catch_all_mode <= 1'b0;
      o_tx_abort <= 1'b0;
      o_stamp_tick <= 1'b0;
      o_bit_timing_one <= `CANCER_RESET_BYTE;
      o_bit_timing_two <= `CANCER_RESET_BYTE;
      o_baud_prescaler <= `CANCER_RESET_BYTE;
      o_output_config <= `CANCER_RESET_BYTE;
    end else begin
      o_irq_n <= ~|(flags_ff & mask_ff);
      o_bus_off <= bus_ff != CANCER_ACTIVE;
      o_bus_stop <= !active || bus_ff != CANCER_ACTIVE;
      o_osc_stop <= sleep_enable;
      o_catch_all_mode <= ctrl_ff[`CANCER_CTRL_CATCH];
      o_tx_abort <= txchk_ev;
      o_stamp_tick <= stamp_adv;
      o_bit_timing_one <= bt_one_ff;
      o_bit_timing_two <= bt_two_ff;
      o_baud_prescaler <= baud_ff;
      o_output_config <= outcfg_ff;
    end
  end

  // ==========================================================
  // checks
  a_irq_masked: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    !$past(|(flags_ff & mask_ff)) |-> o_irq_n) else $error("irq without masked flag");
  a_flag_clear: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    wr_flags && !soft_clear_request && flags_ff[3] && i_host.wdata[3] |=> flags_ff[3])
    else $error("write one cleared a flag");
  a_tx_flag_set: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    active && i_proto.tx_done |=> flags_ff[1]) else $error("tx flag not set");
  a_warn_flag: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    !soft_clear_request && i_tx_err_count >= 8'd96 |=> flags_ff[2])
    else $error("warning flag missing");
  a_passive_flag: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    !soft_clear_request && i_rx_err_count >= 8'd128 |=> flags_ff[6])
    else $error("passive flag missing");
  a_bt_locked: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    !protected_open |=> $stable(bt_one_ff)) else $error("timing written while locked");
  a_txchk_busoff: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    txchk_limit |=> bus_ff != CANCER_ACTIVE && flags_ff[7]) else $error("no bus-off");
  a_hw_reset_bus: assert property (@(posedge i_clk_sys)
    !i_reset_n |=> bus_ff == CANCER_ACTIVE) else $error("bus-off kept over reset");
  a_ctrl_bit7: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    !ctrl_ff[7]) else $error("control bit 7 set");
endmodule

// >>> verification/cancer_bus_model.sv
// bus-side model: bit ticks with bus level, and wake edges on the receive inputs
`timescale 1ns/100ps
module cancer_bus_model (
  input  wire logic i_clk_sys,   // system clock
  input  wire logic i_run,       // bit ticks enabled
  input  wire logic i_dominant,  // bus dominant at coming ticks
  input  wire logic i_edge_b,    // wake edge on input b, else a
  input  wire logic i_wake,      // request one dominant pulse
  output logic      o_bit_tick,  // one pulse per bit time
  output logic      o_recessive, // bus level, valid with tick
  output logic      o_bus_in_a,  // receive input a
  output logic      o_bus_in_b   // receive input b
);
  logic nxt_tick;
  assign nxt_tick = i_run & ~o_bit_tick;
  initial begin
    o_bit_tick  = 1'b0;
    o_recessive = 1'b0;
    o_bus_in_a  = 1'b1;
    o_bus_in_b  = 1'b1;
  end
  // level is only meaningful with a tick, so it is inverted between ticks
  always @(posedge i_clk_sys) begin
    o_bit_tick  <= nxt_tick;
    o_recessive <= nxt_tick ? ~i_dominant : i_dominant;
    o_bus_in_a  <= ~(i_wake & ~i_edge_b);
    o_bus_in_b  <= ~(i_wake & i_edge_b);
  end
endmodule

// >>> verification/testbench.sv
// self-checking bench for the control and event register bank
`timescale 1ns/100ps
`include "cancer_defs.svh"
module testbench;
  import cancer_pkg::*;
  typedef struct packed {
    logic [3:0] ev;
    logic [7:0] rxe;
    logic [7:0] txe;
    logic [7:0] fl;
  } cancer_row_t;
  logic          i_clk_sys;
  logic          i_reset_n;
  cancer_host_t  host;
  cancer_proto_t proto;
  logic [3:0]    ev;
  logic [7:0]    rxe, txe, rdata, bt1, bt2, baud, ocfg;
  logic [15:0]   rdy;
  logic          cs_n, run, dom, wake, edge_b, tick, rec, bus_a, bus_b;
  logic          irq_n, bus_off, bus_stop, osc_stop, catch_all, abort, stamp;
  int            num_errors = 0;
  int            n_tests = 0;
  int            n_abort = 0;
  int            n_cyc = 0;
  int            t0;
  logic [7:0]    ra [7] = '{`CANCER_ADDR_CTRL, `CANCER_ADDR_BT_ONE, `CANCER_ADDR_BT_TWO,
                            `CANCER_ADDR_OUTCFG, `CANCER_ADDR_IRQ_MASK, `CANCER_ADDR_FLAGS, 8'h30};
  cancer_row_t   rows [6] = '{'{4'h8, 8'h00, 8'h00, 8'h01}, '{4'h4, 8'h00, 8'h00, 8'h02},
                              '{4'h2, 8'h00, 8'h00, 8'h08}, '{4'h0, 8'h5F, 8'h5F, 8'h00},
                              '{4'h0, 8'h00, 8'h60, 8'h04}, '{4'h0, 8'h80, 8'h00, 8'h44}};
  assign proto = '{ev[3], ev[2], ev[1], ev[0], tick, rec};
  cancer_event_regs cancer_event_regs_inst (
    .i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_host(host), .i_proto(proto),
    .i_rx_err_count(rxe), .i_tx_err_count(txe), .i_rx_ready(rdy), .i_chip_select_n(cs_n),
    .i_bus_in_a(bus_a), .i_bus_in_b(bus_b), .o_rdata(rdata), .o_irq_n(irq_n),
    .o_bus_off(bus_off), .o_bus_stop(bus_stop), .o_osc_stop(osc_stop),
    .o_catch_all_mode(catch_all), .o_tx_abort(abort), .o_stamp_tick(stamp),
    .o_bit_timing_one(bt1), .o_bit_timing_two(bt2), .o_baud_prescaler(baud),
    .o_output_config(ocfg));
  cancer_bus_model cancer_bus_model_inst (
    .i_clk_sys(i_clk_sys), .i_run(run), .i_dominant(dom), .i_edge_b(edge_b), .i_wake(wake),
    .o_bit_tick(tick), .o_recessive(rec), .o_bus_in_a(bus_a), .o_bus_in_b(bus_b));
  // ==========================================
  // helpers
  initial begin
    i_clk_sys = 1'b0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end
  always @(posedge i_clk_sys) begin
    n_cyc <= n_cyc + 1;
    if (abort === 1'b1) n_abort <= n_abort + 1;
  end
  initial begin
    repeat (30000) @(posedge i_clk_sys);
    num_errors++;
    report_and_stop();
  end
  task automatic report_and_stop();
    if (num_errors == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    host <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge i_clk_sys);
    host <= '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge i_clk_sys);
    host <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge i_clk_sys);
    host <= '0;
    cyc(1);
    check(rdata, e);
  endtask
  task automatic pe(input logic [3:0] v);
    @(posedge i_clk_sys);
    ev <= v;
    @(posedge i_clk_sys);
    ev <= 4'h0;
  endtask
  task automatic wt();
    repeat (600) begin
      @(posedge i_clk_sys);
      if (stamp === 1'b1) break;
    end
  endtask
  // ==========================================
  // stimulus
  initial begin
    {i_reset_n, run, dom, wake, edge_b, ev, rxe, txe, rdy} = '0;
    host = '0;
    cs_n = 1'b1;
    cyc(4);
    check({irq_n, bus_off}, 2'b10);
    check({bt1, bt2, baud, ocfg}, 32'h0);
    @(posedge i_clk_sys);
    i_reset_n <= 1'b1;
    foreach (ra[i]) rd(ra[i], 8'h00);
    foreach (rows[i]) begin
      wr(`CANCER_ADDR_IRQ_MASK, ~rows[i].fl);
      @(posedge i_clk_sys);
      rxe <= rows[i].rxe;
      txe <= rows[i].txe;
      pe(rows[i].ev);
      cyc(3);
      check(irq_n, 1'b1);
      rd(`CANCER_ADDR_FLAGS, rows[i].fl);
      wr(`CANCER_ADDR_IRQ_MASK, rows[i].fl);
      cyc(2);
      check(irq_n, rows[i].fl == 8'h00);
      @(posedge i_clk_sys);
      rxe <= 8'h00;
      txe <= 8'h00;
      wr(`CANCER_ADDR_FLAGS, 8'h00);
      rd(`CANCER_ADDR_FLAGS, 8'h00);
    end
    pe(4'h8);
    wr(`CANCER_ADDR_FLAGS, 8'hFF);
    rd(`CANCER_ADDR_FLAGS, 8'h01);
    rdy <= 16'h0100;
    wr(`CANCER_ADDR_FLAGS, 8'hFE);
    rd(`CANCER_ADDR_FLAGS, 8'h01);
    rdy <= 16'h0000;
    wr(`CANCER_ADDR_FLAGS, 8'hFE);
    rd(`CANCER_ADDR_FLAGS, 8'h00);
    wr(`CANCER_ADDR_CTRL, 8'hB1);
    rd(`CANCER_ADDR_CTRL, 8'h31);
    check(catch_all, 1'b1);
    wr(`CANCER_ADDR_CTRL, 8'h00);
    cyc(2);
    check(catch_all, 1'b0);
    wr(`CANCER_ADDR_MODE, 8'h01);
    wr(`CANCER_ADDR_BT_ONE, 8'h33);
    cyc(1);
    check(bt1, 8'h00);
    wr(`CANCER_ADDR_MODE, 8'h03);
    wr(`CANCER_ADDR_BT_ONE, 8'h5A);
    cyc(1);
    check(bt1, 8'h5A);
    cyc(2);
    check(bt1, 8'h00);
    wr(`CANCER_ADDR_MODE, 8'h00);
    pe(4'h1);
    wr(`CANCER_ADDR_CTRL, 8'h02);
    repeat (3) pe(4'h1);
    cyc(2);
    check({n_abort[3:0], bus_off}, 5'h06);
    pe(4'h1);
    cyc(2);
    check({bus_off, bus_stop}, 2'b11);
    rd(`CANCER_ADDR_FLAGS, 8'hA0);
    wr(`CANCER_ADDR_MODE, 8'h02);
    cyc(1);
    check(bus_stop, 1'b1);
    wr(`CANCER_ADDR_MODE, 8'h00);
    run <= 1'b1;
    cyc(2000);
    dom <= 1'b1;
    cyc(2);
    dom <= 1'b0;
    // phases already counted survive the dominant bit; only the open phase restarts
    cyc(780);
    check(bus_off, 1'b1);
    cyc(80);
    check(bus_off, 1'b0);
    for (int i = 0; i < 5; i++) begin
      if (i == 4) wr(`CANCER_ADDR_MODE, 8'h01);
      wr(`CANCER_ADDR_CTRL, (i == 4) ? 8'h40 : 8'(i << 4));
      wt();
      wt();
      t0 = n_cyc;
      wt();
      check(n_cyc - t0, (i == 4) ? 2 : 64 << i);
    end
    wr(`CANCER_ADDR_CTRL, 8'h00);
    wr(`CANCER_ADDR_MODE, 8'h00);
    run <= 1'b0;
    for (int s = 0; s < 3; s++) begin
      wr(`CANCER_ADDR_CTRL, 8'h04);
      cyc(2);
      check(osc_stop, 1'b1);
      edge_b <= (s == 1);
      wake <= (s < 2);
      cs_n <= (s < 2);
      @(posedge i_clk_sys);
      wake <= 1'b0;
      cs_n <= 1'b1;
      cyc(3);
      check(osc_stop, 1'b0);
      rd(`CANCER_ADDR_FLAGS, 8'h10);
      wr(`CANCER_ADDR_FLAGS, 8'h00);
    end
    wr(`CANCER_ADDR_CTRL, 8'h02);
    repeat (4) pe(4'h1);
    cyc(2);
    check(bus_off, 1'b1);
    i_reset_n <= 1'b0;
    cyc(1);
    check(bus_off, 1'b0);
    i_reset_n <= 1'b1;
    cyc(2);
    check(bus_off, 1'b0);
    report_and_stop();
  end
endmodule
